// ==== hw/syscall_map.svh ====
/*
 Constants of the flash system-call sequencer: keys, opcodes, status
 words, failure reasons and pulse timing.
 Assumes it is included by bare name wherever these values are needed.
*/
`ifndef SYSCALL_MAP_SVH
`define SYSCALL_MAP_SVH

`define CLOCK_PERIOD_NS   10
`define FIRST_CALL_KEY_VALUE        8'hb6
`define SECOND_CALL_KEY_BASE         8'hd3
`define OP_SILICON_ID     8'h00
`define OP_LOAD_BYTES     8'h04
`define OP_WRITE_ROW      8'h05
`define OP_PROGRAM_ROW    8'h06
`define OP_ERASE_ALL      8'h0a
`define OP_CHECKSUM       8'h0b
`define OP_NB_WRITE_ROW   8'h07
`define OP_NB_PROGRAM_ROW 8'h08
`define OP_RESUME_NB      8'h09
`define STATUS_OK         32'ha000_0000
`define STATUS_FAIL_BASE  32'hf000_0000
`define ERR_BAD_OPCODE    8'h01
`define ERR_BAD_KEY       8'h02
`define ERR_NB_DEBUG      8'h03
`define ERR_NO_RESUME     8'h04
`define ERR_FLASH_BUSY    8'h05
`define PULSE_TIME_NS     6000000
`define PULSE_CYCLES      (`PULSE_TIME_NS / `CLOCK_PERIOD_NS)
`define PHASE_PRE         3'b001
`define PHASE_ERASE       3'b010
`define PHASE_PROGRAM     3'b100
`define PHASES_WRITE      3'b111

`endif

// ==== hw/syscall_pkg.sv ====
/*
 Types of the flash system-call sequencer.
 Assumes syscall_map.svh supplies the numeric constants.
*/
package syscall_pkg;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'b000_0001,
    ST_CHECK = 7'b000_0010,
    ST_ARM   = 7'b000_0100,
    ST_XFER  = 7'b000_1000,
    ST_PULSE = 7'b001_0000,
    ST_PAUSE = 7'b010_0000,
    ST_SUM   = 7'b100_0000
  } seq_state_t;

  typedef logic [7:0]  opcode_t;
  typedef logic [31:0] word_t;

endpackage : syscall_pkg

// ==== hw/hv_pulse_gen.sv ====
/*
 High-voltage pulse generator: one timed program or erase pulse per start.
 Assumes start is a one-cycle pulse given only while no pulse runs.
*/
`timescale 1ns/100ps

module hv_pulse_gen #(
  parameter int PULSE_CYCLES = 600000
) (
  input  wire logic clock,        // System clock.
  input  wire logic reset,        // Synchronous reset, active high.
  input  wire logic start,        // Begin one pulse.
  input  wire logic erase,        // Pulse is an erase, else a program.
  input  wire logic all_cells,    // Pulse acts on every cell of the row.
  output logic      hv_enable,    // High voltage applied.
  output logic      hv_erase,     // Polarity of the applied pulse.
  output logic      hv_all_cells, // Pulse covers all cells.
  output logic      done          // One cycle at the end of the pulse.
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(PULSE_CYCLES - 1);

  logic [CW-1:0] count_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      hv_enable    <= 1'b0;
      hv_erase     <= 1'b0;
      hv_all_cells <= 1'b0;
      count_q      <= '0;
    end else if (start) begin
      hv_enable    <= 1'b1;
      hv_erase     <= erase;
      hv_all_cells <= all_cells;
      count_q      <= '0;
    end else if (hv_enable) begin
      if (count_q == LAST) begin
        hv_enable <= 1'b0;
      end
      count_q <= count_q + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      done <= 1'b0;
    end else begin
      done <= hv_enable && !start && (count_q == LAST);
    end
  end

endmodule : hv_pulse_gen

// ==== hw/flash_system_call_sequencer.sv ====
/*
 Flash system-call sequencer: keyed calls, page latch, PROGRAM_ERASE_PROGRAM_SEQUENCE row writes,
 checksum and non-blocking sub-operation interrupts.
 Assumes requests come from logic on the same clock and that the flash
 array returns read data the cycle after a read strobe.
*/
`timescale 1ns/100ps
`include "syscall_map.svh"

module flash_system_call_sequencer #(
  parameter int          LATCH_BYTES  = 128,
  parameter int          PULSE_CYCLES = `PULSE_CYCLES,
  parameter logic [31:0] SILICON_ID   = 32'h0000_1234 // Arbitrary value.
) (
  input  wire logic                 clock,          // System clock.
  input  wire logic                 reset,          // Sync reset, high.
  input  wire logic                 call_start,     // Request bit written.
  input  wire logic [15:0]          call_opcode_field, // Command field.
  input  wire syscall_pkg::word_t   call_argument,  // Argument word.
  input  wire logic                 from_debug,     // Requester is debug.
  input  wire logic [7:0]           flash_rd_data,  // Array read byte.
  output logic                      call_request_bit, // Call pending.
  output logic                      call_privileged,  // Call executing.
  output syscall_pkg::word_t        status_word,    // Completion status.
  output syscall_pkg::word_t        result_word,    // Returned value.
  output logic                      call_nmi,       // Core entry pulse.
  output logic                      cpu_stall,      // Core held.
  output logic                      seq_irq,        // Sub-operation done.
  output logic [15:0]               flash_row,      // Target row.
  output logic                      flash_wr_strobe, // Latch byte to row.
  output logic [$clog2(LATCH_BYTES)-1:0] flash_index, // Byte in row.
  output logic [7:0]                flash_wr_data,  // Byte written.
  output logic                      flash_rd_strobe, // Row byte read.
  output logic                      hv_enable,      // Pulse applied.
  output logic                      hv_erase,       // Erase polarity.
  output logic                      hv_all_cells    // Whole-row pulse.
);
  import syscall_pkg::*;

  localparam int IW = $clog2(LATCH_BYTES);
  localparam logic [IW-1:0] LAST_IDX = IW'(LATCH_BYTES - 1);

  seq_state_t    state_q;
  opcode_t       op_q;
  logic [7:0]    cmd_hi_q;
  word_t         arg_q;
  logic          dbg_q;
  logic [2:0]    phase_q;
  logic          nb_q;
  logic          paused_q;
  logic          all_rows_q;
  logic [IW-1:0] idx_q;
  logic          pulse_start_q;
  logic          pulse_done;
  logic          rel_q;
  word_t         rel_status_q;
  logic          rd_valid_q;
  logic          rd_done_q;
  logic [IW-1:0] acc_cnt_q;
  word_t         sum_q;
  logic [7:0]    latch_mem [LATCH_BYTES];

  function automatic logic is_nonblocking(input opcode_t op);
    return (op == `OP_NB_WRITE_ROW) || (op == `OP_NB_PROGRAM_ROW) ||
           (op == `OP_RESUME_NB);
  endfunction : is_nonblocking

  function automatic word_t fail_word(input logic [7:0] code);
    return `STATUS_FAIL_BASE | {24'h0, code};
  endfunction : fail_word

  wire accept = call_start &&
                ((state_q == ST_IDLE) || (state_q == ST_PAUSE));
  wire key_ok = (arg_q[7:0] == `FIRST_CALL_KEY_VALUE) && (cmd_hi_q == 8'h00) &&
                (arg_q[15:8] == 8'(`SECOND_CALL_KEY_BASE + op_q));
  wire [2:0] cur_phase = phase_q & (~phase_q + 3'h1);
  wire [2:0] left_phase = phase_q & ~cur_phase;

  hv_pulse_gen #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_pulse (
    .clock        (clock),
    .reset        (reset),
    .start        (pulse_start_q),
    .erase        (cur_phase == `PHASE_ERASE),
    .all_cells    ((cur_phase != `PHASE_PROGRAM) || all_rows_q),
    .hv_enable    (hv_enable),
    .hv_erase     (hv_erase),
    .hv_all_cells (hv_all_cells),
    .done         (pulse_done)
  );

  // Sequencer: decodes the call and walks the row phases.
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q       <= ST_IDLE;
      op_q          <= '0;
      cmd_hi_q      <= '0;
      arg_q         <= '0;
      dbg_q         <= 1'b0;
      phase_q       <= '0;
      nb_q          <= 1'b0;
      paused_q      <= 1'b0;
      all_rows_q    <= 1'b0;
      idx_q         <= '0;
      pulse_start_q <= 1'b0;
      rel_q         <= 1'b0;
      rel_status_q  <= '0;
      seq_irq       <= 1'b0;
    end else begin
      pulse_start_q <= 1'b0;
      rel_q         <= 1'b0;
      seq_irq       <= 1'b0;
      unique case (state_q)
        ST_IDLE, ST_PAUSE: begin
          if (accept) begin
            op_q     <= call_opcode_field[7:0];
            cmd_hi_q <= call_opcode_field[15:8];
            arg_q    <= call_argument;
            dbg_q    <= from_debug;
            state_q  <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          rel_q        <= 1'b1;
          rel_status_q <= `STATUS_OK;
          state_q      <= paused_q ? ST_PAUSE : ST_IDLE;
          if (!key_ok) begin
            rel_status_q <= fail_word(`ERR_BAD_KEY);
          end else if (paused_q && op_q != `OP_RESUME_NB) begin
            rel_status_q <= fail_word(`ERR_FLASH_BUSY);
          end else begin
            unique case (op_q)
              `OP_SILICON_ID, `OP_LOAD_BYTES: begin
              end
              `OP_WRITE_ROW, `OP_PROGRAM_ROW, `OP_ERASE_ALL: begin
                rel_q      <= 1'b0;
                nb_q       <= 1'b0;
                all_rows_q <= (op_q == `OP_ERASE_ALL);
                phase_q    <= (op_q == `OP_WRITE_ROW) ? `PHASES_WRITE :
                              (op_q == `OP_ERASE_ALL) ? `PHASE_ERASE :
                                                        `PHASE_PROGRAM;
                state_q    <= ST_ARM;
              end
              `OP_NB_WRITE_ROW, `OP_NB_PROGRAM_ROW: begin
                if (dbg_q) begin
                  rel_status_q <= fail_word(`ERR_NB_DEBUG);
                end else begin
                  nb_q       <= 1'b1;
                  all_rows_q <= 1'b0;
                  phase_q    <= (op_q == `OP_NB_WRITE_ROW) ?
                                `PHASES_WRITE : `PHASE_PROGRAM;
                  state_q    <= ST_ARM;
                end
              end
              `OP_RESUME_NB: begin
                if (!paused_q) begin
                  rel_status_q <= fail_word(`ERR_NO_RESUME);
                end else begin
                  paused_q <= 1'b0;
                  state_q  <= ST_ARM;
                end
              end
              `OP_CHECKSUM: begin
                rel_q   <= 1'b0;
                idx_q   <= '0;
                state_q <= ST_SUM;
              end
              default: begin
                rel_status_q <= fail_word(`ERR_BAD_OPCODE);
              end
            endcase
          end
        end
        ST_ARM: begin
          idx_q <= '0;
          if (phase_q == 3'b000) begin
            state_q <= ST_IDLE;
          end else if (cur_phase == `PHASE_PROGRAM) begin
            state_q <= ST_XFER;
          end else begin
            pulse_start_q <= 1'b1;
            state_q       <= ST_PULSE;
          end
        end
        ST_XFER: begin
          idx_q <= idx_q + IW'(1);
          if (idx_q == LAST_IDX) begin
            pulse_start_q <= 1'b1;
            state_q       <= ST_PULSE;
          end
        end
        ST_PULSE: begin
          if (pulse_done) begin
            phase_q <= left_phase;
            if (nb_q) begin
              seq_irq  <= 1'b1;
              paused_q <= 1'b1;
              state_q  <= ST_PAUSE;
            end else if (left_phase == 3'b000) begin
              rel_q        <= 1'b1;
              rel_status_q <= `STATUS_OK;
              state_q      <= ST_IDLE;
            end else begin
              state_q <= ST_ARM;
            end
          end
        end
        ST_SUM: begin
          if (idx_q != LAST_IDX) begin
            idx_q <= idx_q + IW'(1);
          end
          if (rd_valid_q && acc_cnt_q == LAST_IDX) begin
            rel_q        <= 1'b1;
            rel_status_q <= `STATUS_OK;
            state_q      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Page latch staging by the load-bytes call.
  always_ff @(posedge clock) begin
    if (state_q == ST_CHECK && key_ok && !paused_q &&
        op_q == `OP_LOAD_BYTES) begin
      latch_mem[arg_q[16+IW-1:16]] <= arg_q[31:24];
    end
  end

  // Flash port: latch bytes out during transfer, row reads during sums.
  always_ff @(posedge clock) begin
    if (reset) begin
      flash_row       <= '0;
      flash_wr_strobe <= 1'b0;
      flash_rd_strobe <= 1'b0;
      flash_index     <= '0;
      flash_wr_data   <= '0;
    end else begin
      if (state_q == ST_CHECK) begin
        flash_row <= arg_q[31:16];
      end
      flash_wr_strobe <= (state_q == ST_XFER);
      flash_rd_strobe <= (state_q == ST_SUM) && !rd_done_q;
      flash_index     <= idx_q;
      flash_wr_data   <= latch_mem[idx_q];
    end
  end

  // Checksum accumulation over the row read back.
  always_ff @(posedge clock) begin
    if (reset || state_q == ST_CHECK) begin
      rd_done_q  <= 1'b0;
      rd_valid_q <= 1'b0;
      acc_cnt_q  <= '0;
      sum_q      <= '0;
    end else begin
      rd_valid_q <= flash_rd_strobe;
      if (state_q == ST_SUM && idx_q == LAST_IDX) begin
        rd_done_q <= 1'b1;
      end
      if (rd_valid_q) begin
        sum_q     <= sum_q + {24'h0, flash_rd_data};
        acc_cnt_q <= acc_cnt_q + IW'(1);
      end
    end
  end

  // Requester-facing flags, status and result words.
  always_ff @(posedge clock) begin
    if (reset) begin
      call_request_bit <= 1'b0;
      call_privileged  <= 1'b0;
      status_word      <= '0;
      result_word      <= '0;
      call_nmi         <= 1'b0;
      cpu_stall        <= 1'b0;
    end else begin
      call_nmi <= accept && !from_debug;
      if (accept) begin
        call_request_bit <= 1'b1;
        cpu_stall        <= !from_debug &&
                            !is_nonblocking(call_opcode_field[7:0]);
      end else if (rel_q) begin
        call_request_bit <= 1'b0;
        call_privileged  <= 1'b0;
        cpu_stall        <= 1'b0;
        status_word      <= rel_status_q;
      end else if (state_q == ST_CHECK) begin
        call_privileged <= 1'b1;
      end
      if (state_q == ST_CHECK && key_ok && op_q == `OP_SILICON_ID) begin
        result_word <= SILICON_ID;
      end else if (state_q == ST_SUM && rd_valid_q &&
                   acc_cnt_q == LAST_IDX) begin
        result_word <= sum_q + {24'h0, flash_rd_data};
      end
    end
  end

endmodule : flash_system_call_sequencer

// ==== dv/flash_array_model.sv ====
/*
 Behavioural flash row: keeps bytes that the sequencer writes and answers
 row reads with a fixed pattern one cycle after the read strobe.
 Assumes the sequencer's clock and a 128-byte row.
*/
`timescale 1ns/100ps

module flash_array_model (
  input  wire logic       clock,           // System clock.
  input  wire logic       flash_wr_strobe, // Byte write.
  input  wire logic       flash_rd_strobe, // Byte read.
  input  wire logic [6:0] flash_index,     // Byte in row.
  input  wire logic [7:0] flash_wr_data,   // Byte written.
  output logic      [7:0] flash_rd_data    // Byte read back.
);
  logic [7:0] written [128];

  initial flash_rd_data = 8'h00;

  // Outside a read the data line toggles so stale bytes never look valid.
  always @(posedge clock) begin
    if (flash_wr_strobe) written[flash_index] <= flash_wr_data;
    if (flash_rd_strobe) flash_rd_data <= {1'b0, flash_index} ^ 8'h5a;
    else flash_rd_data <= ~flash_rd_data;
  end
endmodule : flash_array_model

// ==== dv/flash_system_call_sequencer_properties.sv ====
/*
 Concurrent checks on the sequencer's ports.
 Assumes binding to flash_system_call_sequencer and syscall_map.svh.
*/
`timescale 1ns/100ps
`include "syscall_map.svh"

module sequencer_properties #(
  parameter int          LATCH_BYTES  = 128,
  parameter int          PULSE_CYCLES = 20,
  parameter logic [31:0] SILICON_ID   = 32'h0000_0000
) (
  input wire logic               clock,             // System clock.
  input wire logic               reset,             // Sync reset.
  input wire logic               call_start,        // Start request.
  input wire logic [15:0]        call_opcode_field, // Command field.
  input wire syscall_pkg::word_t call_argument,     // Argument word.
  input wire logic               call_request_bit,  // Call pending.
  input wire logic               call_privileged,   // Call executing.
  input wire syscall_pkg::word_t status_word,       // Status.
  input wire syscall_pkg::word_t result_word,       // Result.
  input wire logic               call_nmi,          // Core entry.
  input wire logic               cpu_stall,         // Core held.
  input wire logic               seq_irq,           // Sub-op done.
  input wire logic               flash_wr_strobe,   // Byte write.
  input wire logic               hv_enable,         // Pulse on.
  input wire logic               hv_erase,          // Erase pulse.
  input wire logic               hv_all_cells       // Whole row.
);
  logic idle_start;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  assign idle_start = call_start && !call_request_bit && !call_privileged
                      && !cpu_stall;

  a_nmi_one_cycle: assert property (call_nmi |=> !call_nmi)
    else $error("entry pulse longer than one cycle");
  a_irq_one_cycle: assert property (seq_irq |=> !seq_irq)
    else $error("sub-operation pulse longer than one cycle");
  a_request_priv_set: assert property (
    $rose(call_request_bit) |=> call_privileged)
    else $error("request raised without in-progress");
  a_release_both_clear: assert property (
    $fell(call_request_bit) |-> !call_privileged)
    else $error("in-progress left set at release");
  a_release_status_form: assert property (
    $fell(call_request_bit) |-> status_word[31:28] == 4'ha
      || status_word[31:8] == 24'hf00000)
    else $error("status word malformed at release");
  a_no_xfer_in_pulse: assert property (
    flash_wr_strobe |-> !hv_enable)
    else $error("latch transfer during a pulse");
  a_erase_whole_row: assert property (
    hv_enable && hv_erase |-> hv_all_cells)
    else $error("erase pulse not on whole row");
  a_stall_in_call: assert property (
    cpu_stall && !$rose(cpu_stall) |-> call_privileged)
    else $error("core held outside a call");
  a_bad_key_fails: assert property (
    idle_start && call_argument[7:0] != `FIRST_CALL_KEY_VALUE |-> ##[1:4]
      ($fell(call_request_bit) && status_word[31:28] == 4'hf))
    else $error("bad key did not fail");
  a_id_result_word: assert property (
    idle_start && call_opcode_field == 16'h0000
      && call_argument[15:0] == {`SECOND_CALL_KEY_BASE, `FIRST_CALL_KEY_VALUE} |-> ##[1:4]
      ($fell(call_request_bit) && result_word == SILICON_ID))
    else $error("identity result wrong");
endmodule : sequencer_properties

bind flash_system_call_sequencer sequencer_properties #(
  .LATCH_BYTES(LATCH_BYTES), .PULSE_CYCLES(PULSE_CYCLES),
  .SILICON_ID(SILICON_ID)) props (
  .clock(clock), .reset(reset), .call_start(call_start),
  .call_opcode_field(call_opcode_field), .call_argument(call_argument),
  .call_request_bit(call_request_bit), .call_privileged(call_privileged),
  .status_word(status_word), .result_word(result_word),
  .call_nmi(call_nmi), .cpu_stall(cpu_stall), .seq_irq(seq_irq),
  .flash_wr_strobe(flash_wr_strobe), .hv_enable(hv_enable),
  .hv_erase(hv_erase), .hv_all_cells(hv_all_cells));

// ==== dv/flash_system_call_sequencer_test.sv ====
/*
 Self-checking bench of the system-call sequencer with a flash row model.
 Assumes a short pulse parameter so row writes finish quickly.
*/
`timescale 1ns/100ps
`include "syscall_map.svh"

module flash_system_call_sequencer_test;
  import syscall_pkg::*;
  localparam word_t SIL_ID = 32'h0000_1234; // Arbitrary value.
  logic clock = 0, reset = 1, call_start = 0, from_debug = 0;
  logic [15:0] call_opcode_field = 16'h0;
  word_t call_argument = 32'h0, status_word, result_word;
  logic [7:0] rd_data, wr_data;
  logic [6:0] index;
  logic req, priv, nmi, stall, irq, wr, rd, hv, hv_q;
  int err_count = 0, compares = 0, cycles = 0;
  int nmi_n = 0, irq_n = 0, stall_n = 0, hv_n = 0, n0, k, w;
  word_t sum;

  flash_system_call_sequencer #(.PULSE_CYCLES(20), .SILICON_ID(SIL_ID)) dut (
    .clock(clock), .reset(reset), .call_start(call_start),
    .call_opcode_field(call_opcode_field), .call_argument(call_argument),
    .from_debug(from_debug), .flash_rd_data(rd_data),
    .call_request_bit(req), .call_privileged(priv),
    .status_word(status_word), .result_word(result_word), .call_nmi(nmi),
    .cpu_stall(stall), .seq_irq(irq), .flash_row(),
    .flash_wr_strobe(wr), .flash_index(index), .flash_wr_data(wr_data),
    .flash_rd_strobe(rd), .hv_enable(hv), .hv_erase(), .hv_all_cells());
  flash_array_model model (.clock(clock), .flash_wr_strobe(wr),
    .flash_rd_strobe(rd), .flash_index(index), .flash_wr_data(wr_data),
    .flash_rd_data(rd_data));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    hv_q <= hv;
    if (nmi === 1'b1) nmi_n++;
    if (irq === 1'b1) irq_n++;
    if (stall === 1'b1) stall_n++;
    if (hv === 1'b1 && hv_q !== 1'b1) hv_n++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input word_t exp, input word_t got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  function automatic word_t keyed(input logic [7:0] op, input word_t hi);
    return {hi[15:0], op + `SECOND_CALL_KEY_BASE, `FIRST_CALL_KEY_VALUE};
  endfunction : keyed

  // Opcode and argument go out with the start pulse, never after it.
  task automatic call(input logic [15:0] fld, input word_t arg,
                      input logic dbg);
    int n;
    n = 0;
    call_start <= 1'b1;
    call_opcode_field <= fld;
    call_argument <= arg;
    from_debug <= dbg;
    @(posedge clock);
    call_start <= 1'b0;
    while (req !== 1'b1 && n < 20) begin
      @(posedge clock);
      n++;
    end
    while (req !== 1'b0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    #1;
  endtask : call

  function automatic word_t fail(input logic [7:0] why);
    return {24'hf00000, why};
  endfunction : fail

  task automatic t_ident();
    n0 = nmi_n;
    call(16'h0000, keyed(`OP_SILICON_ID, 0), 1'b0);
    chk("status", `STATUS_OK, status_word);
    chk("result", SIL_ID, result_word);
    call(16'h0000, keyed(`OP_SILICON_ID, 0), 1'b1);
    chk("nmi count", 32'd1, word_t'(nmi_n - n0));
    $display("ident test done");
  endtask : t_ident

  task automatic t_keys();
    call(16'h0000, {16'h0, 8'hd3, 8'hb5}, 1'b0);
    chk("first_call_key", fail(`ERR_BAD_KEY), status_word);
    call(16'h0000, {16'h0, 8'hd4, 8'hb6}, 1'b0);
    chk("second_call_key", fail(`ERR_BAD_KEY), status_word);
    call(16'h0100, keyed(8'h00, 0), 1'b0);
    chk("high byte", fail(`ERR_BAD_KEY), status_word);
    call(16'h0033, keyed(8'h33, 0), 1'b0);
    chk("opcode", fail(`ERR_BAD_OPCODE), status_word);
    call({8'h0, `OP_RESUME_NB}, keyed(`OP_RESUME_NB, 0), 1'b0);
    chk("lone resume", fail(`ERR_NO_RESUME), status_word);
    call({8'h0, `OP_NB_WRITE_ROW}, keyed(`OP_NB_WRITE_ROW, 5), 1'b1);
    chk("nb debug", fail(`ERR_NB_DEBUG), status_word);
    $display("key test done");
  endtask : t_keys

  task automatic t_write();
    call({8'h0, `OP_LOAD_BYTES}, keyed(`OP_LOAD_BYTES, 16'h3c00), 1'b0);
    call({8'h0, `OP_LOAD_BYTES}, keyed(`OP_LOAD_BYTES, 16'hc37f), 1'b0);
    n0 = stall_n;
    k = hv_n;
    fork
      call({8'h0, `OP_WRITE_ROW}, keyed(`OP_WRITE_ROW, 5), 1'b0);
      begin
        repeat (10) @(posedge clock);
        call_start <= 1'b1;
        call_opcode_field <= 16'h0000;
        call_argument <= keyed(`OP_SILICON_ID, 0);
        @(posedge clock);
        call_start <= 1'b0;
        #1 chk("busy req", 32'd1, word_t'(req));
      end
    join
    chk("status", `STATUS_OK, status_word);
    chk("stalled", 32'd1, word_t'(stall_n > n0));
    chk("pulses", 32'd3, word_t'(hv_n - k));
    chk("byte 0", 32'h3c, word_t'(model.written[0]));
    chk("byte 127", 32'hc3, word_t'(model.written[127]));
    call({8'h0, `OP_CHECKSUM}, keyed(`OP_CHECKSUM, 5), 1'b0);
    sum = 0;
    for (int i = 0; i < 128; i++) sum += word_t'(8'(i) ^ 8'h5a);
    chk("checksum", sum, result_word);
    $display("write test done");
  endtask : t_write

  task automatic t_nonblock(input logic [7:0] op, input int subs);
    n0 = irq_n;
    w = stall_n;
    call({8'h0, op}, keyed(op, 5), 1'b0);
    chk("nb start", `STATUS_OK, status_word);
    for (int s = 0; s < subs; s++) begin
      k = 0;
      while (irq_n <= n0 + s && k < 600) begin
        @(posedge clock);
        k++;
      end
      if (s == 0) begin
        call({8'h0, `OP_CHECKSUM}, keyed(`OP_CHECKSUM, 5), 1'b0);
        chk("paused", fail(`ERR_FLASH_BUSY), status_word);
        // The refused call is blocking, so it holds the core two cycles.
        w += 2;
      end
      call({8'h0, `OP_RESUME_NB}, keyed(`OP_RESUME_NB, 0), 1'b0);
      chk("resume", `STATUS_OK, status_word);
    end
    repeat (300) @(posedge clock);
    chk("irq count", word_t'(subs), word_t'(irq_n - n0));
    chk("no stall", 32'd0, word_t'(stall_n - w));
    $display("non-blocking test done");
  endtask : t_nonblock

  initial begin
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    t_ident();
    t_keys();
    t_write();
    t_nonblock(`OP_NB_WRITE_ROW, 3);
    t_nonblock(`OP_NB_PROGRAM_ROW, 1);
    give_verdict();
  end
endmodule : flash_system_call_sequencer_test
